/* File: src/eipp_consts.svh */
`ifndef EIPP_CONSTS_SVH
`define EIPP_CONSTS_SVH

// Register byte addresses
`define EIPP_ADDR_EXT_CTRL 8'h00
`define EIPP_ADDR_PERI_PRIO 8'h04
`define EIPP_ADDR_RESET_CTRL 8'h08
`define EIPP_ADDR_PERI_ENABLE 8'h0c
`define EIPP_ADDR_PERI_FLAG 8'h10
`define EIPP_ADDR_IRQ_STATUS 8'h14
`define EIPP_ADDR_IRQ_MASK 8'h18

// One-hot register select positions
`define EIPP_SEL_EXT_CTRL 0
`define EIPP_SEL_PERI_PRIO 1
`define EIPP_SEL_RESET_CTRL 2
`define EIPP_SEL_PERI_ENABLE 3
`define EIPP_SEL_PERI_FLAG 4
`define EIPP_SEL_IRQ_STATUS 5
`define EIPP_SEL_IRQ_MASK 6

// External control and reset control field positions
`define EIPP_BIT_A_FLAG 0
`define EIPP_BIT_B_FLAG 1
`define EIPP_BIT_A_EN 3
`define EIPP_BIT_B_EN 4
`define EIPP_BIT_A_PRIO 6
`define EIPP_BIT_B_PRIO 7
`define EIPP_BIT_PRIO_LEVELS 7

// Writable masks and reset values
`define EIPP_EXT_CTRL_MASK 8'hdb
`define EIPP_EXT_CTRL_RESET 8'hc0
`define EIPP_PERI_MASK 8'h7f
`define EIPP_PERI_PRIO_RESET 8'h7f
`define EIPP_RESET_CTRL_MASK 8'h80
`define EIPP_ZERO8 8'h00

// Interrupt status bits
`define EIPP_STAT_A 0
`define EIPP_STAT_B 1
`define EIPP_STAT_HIGH 2
`define EIPP_STAT_LOW 3
`define EIPP_STAT_MASK 4'hf

// AHB encodings
`define EIPP_HTRANS_NONSEQ 2'b10
`define EIPP_AWORD_MSB 7
`define EIPP_AWORD_LSB 2

`endif

/* File: src/eipp_pkg.sv */
package eipp_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } eipp_req_type;

  typedef struct packed {
    logic high;
    logic low;
  } eipp_core_req_type;

endpackage : eipp_pkg

/* File: src/eipp_top.sv */
`timescale 1ns/1ps
`include "eipp_consts.svh"

module eipp_top
  import eipp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_input_a,
  input wire logic ext_irq_input_b,
  input wire logic [6:0] peri_irq_request,
  output logic core_irq_high,
  output logic core_irq_low,
  output logic irq
);

  // Edge detect helper on agreed synchronised samples
  function automatic logic rise(input logic s2, input logic s3, input logic last);
    return (s2 == s3) && s3 && !last;
  endfunction : rise

  // Pin synchronisers, three stages, change counted when stage 2 and 3 agree
  logic [2:0] sync_a_q, sync_a_d, sync_b_q, sync_b_d;
  logic lvl_a_q, lvl_a_d, lvl_b_q, lvl_b_d;
  logic evt_a, evt_b;

  always_comb begin
    sync_a_d = {sync_a_q[1:0], ext_irq_input_a};
    sync_b_d = {sync_b_q[1:0], ext_irq_input_b};
    evt_a = rise(sync_a_q[1], sync_a_q[2], lvl_a_q);
    evt_b = rise(sync_b_q[1], sync_b_q[2], lvl_b_q);
    lvl_a_d = (sync_a_q[1] == sync_a_q[2]) ? sync_a_q[2] : lvl_a_q;
    lvl_b_d = (sync_b_q[1] == sync_b_q[2]) ? sync_b_q[2] : lvl_b_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a_q <= 3'h0;
      sync_b_q <= 3'h0;
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
    end else begin
      sync_a_q <= sync_a_d;
      sync_b_q <= sync_b_d;
      lvl_a_q <= lvl_a_d;
      lvl_b_q <= lvl_b_d;
    end
  end

  // One-hot register select from a word address, zero when unmapped
  function automatic logic [6:0] reg_hit(input logic [7:0] addr);
    logic [6:0] hit;
    hit = 7'h00;
    unique case (addr)
      `EIPP_ADDR_EXT_CTRL: hit[`EIPP_SEL_EXT_CTRL] = 1'b1;
      `EIPP_ADDR_PERI_PRIO: hit[`EIPP_SEL_PERI_PRIO] = 1'b1;
      `EIPP_ADDR_RESET_CTRL: hit[`EIPP_SEL_RESET_CTRL] = 1'b1;
      `EIPP_ADDR_PERI_ENABLE: hit[`EIPP_SEL_PERI_ENABLE] = 1'b1;
      `EIPP_ADDR_PERI_FLAG: hit[`EIPP_SEL_PERI_FLAG] = 1'b1;
      `EIPP_ADDR_IRQ_STATUS: hit[`EIPP_SEL_IRQ_STATUS] = 1'b1;
      `EIPP_ADDR_IRQ_MASK: hit[`EIPP_SEL_IRQ_MASK] = 1'b1;
      default: hit = 7'h00;
    endcase
    return hit;
  endfunction : reg_hit

  // AHB address phase capture and data phase answer
  eipp_req_type req_q, req_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic resp_q, resp_d;

  // Transfer qualified by select, ready and a non-sequential start
  always_comb begin
    req_d.addr = {haddr[`EIPP_AWORD_MSB:`EIPP_AWORD_LSB], 2'b00};
    req_d.write = hwrite;
    req_d.valid = hsel && hready && (htrans == `EIPP_HTRANS_NONSEQ);
  end

  // Register state
  logic [7:0] ext_ctrl_q, ext_ctrl_d;
  logic [7:0] peri_prio_q, peri_prio_d;
  logic [7:0] reset_ctrl_q, reset_ctrl_d;
  logic [7:0] peri_en_q, peri_en_d;
  logic [7:0] peri_flag_q, peri_flag_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] mask_q, mask_d;
  logic hi_q, hi_d, lo_q, lo_d, irq_q, irq_d;
  eipp_core_req_type core_req;
  logic wr;
  logic [7:0] wb;
  logic [6:0] wr_hit;
  logic [6:0] rd_hit;

  // Request routing to the core
  always_comb begin
    logic [8:0] pend;
    logic [8:0] prio;
    logic two_level;
    pend = '0;
    prio = '0;
    two_level = reset_ctrl_q[`EIPP_BIT_PRIO_LEVELS];
    pend[0] = ext_ctrl_q[`EIPP_BIT_A_FLAG] && ext_ctrl_q[`EIPP_BIT_A_EN];
    pend[1] = ext_ctrl_q[`EIPP_BIT_B_FLAG] && ext_ctrl_q[`EIPP_BIT_B_EN];
    pend[8:2] = peri_flag_q[6:0] & peri_en_q[6:0];
    prio[0] = ext_ctrl_q[`EIPP_BIT_A_PRIO];
    prio[1] = ext_ctrl_q[`EIPP_BIT_B_PRIO];
    prio[8:2] = peri_prio_q[6:0];
    // Single level mode routes every request as high
    if (!two_level) begin
      prio = '1;
    end
    core_req.high = |(pend & prio);
    core_req.low = |(pend & ~prio);
  end

  // Bus write strobe and register selects for both phases
  always_comb begin
    wr = req_q.valid && req_q.write;
    wb = hwdata[7:0];
    wr_hit = wr ? reg_hit(req_q.addr) : 7'h00;
    rd_hit = (req_d.valid && !req_d.write) ? reg_hit(req_d.addr) : 7'h00;
  end

  // Configuration and flag registers; reserved bits masked on write
  always_comb begin
    ext_ctrl_d = ext_ctrl_q;
    peri_prio_d = peri_prio_q;
    reset_ctrl_d = reset_ctrl_q;
    peri_en_d = peri_en_q;
    peri_flag_d = peri_flag_q;
    if (wr_hit[`EIPP_SEL_EXT_CTRL]) begin
      ext_ctrl_d = wb & `EIPP_EXT_CTRL_MASK;
    end
    if (wr_hit[`EIPP_SEL_PERI_PRIO]) begin
      peri_prio_d = wb & `EIPP_PERI_MASK;
    end
    if (wr_hit[`EIPP_SEL_RESET_CTRL]) begin
      reset_ctrl_d = wb & `EIPP_RESET_CTRL_MASK;
    end
    if (wr_hit[`EIPP_SEL_PERI_ENABLE]) begin
      peri_en_d = wb & `EIPP_PERI_MASK;
    end
    if (wr_hit[`EIPP_SEL_PERI_FLAG]) begin
      peri_flag_d = wb & `EIPP_PERI_MASK;
    end
    // Hardware sets win over a same-cycle software clear, enables ignored
    if (evt_a) begin
      ext_ctrl_d[`EIPP_BIT_A_FLAG] = 1'b1;
    end
    if (evt_b) begin
      ext_ctrl_d[`EIPP_BIT_B_FLAG] = 1'b1;
    end
    peri_flag_d[6:0] = peri_flag_d[6:0] | peri_irq_request;
  end

  // Sticky status, write one to clear, set wins; summary line from next state
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_hit[`EIPP_SEL_IRQ_STATUS]) begin
      stat_d = stat_q & ~wb[3:0];
    end
    if (wr_hit[`EIPP_SEL_IRQ_MASK]) begin
      mask_d = wb[3:0] & `EIPP_STAT_MASK;
    end
    if (evt_a) begin
      stat_d[`EIPP_STAT_A] = 1'b1;
    end
    if (evt_b) begin
      stat_d[`EIPP_STAT_B] = 1'b1;
    end
    if (core_req.high && !hi_q) begin
      stat_d[`EIPP_STAT_HIGH] = 1'b1;
    end
    if (core_req.low && !lo_q) begin
      stat_d[`EIPP_STAT_LOW] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  // Core request lines, one cycle behind the routing
  always_comb begin
    hi_d = core_req.high;
    lo_d = core_req.low;
  end

  // Data phase answer; read data from next state so a read right after a write sees it
  always_comb begin
    ready_d = 1'b1;
    resp_d = 1'b0;
    rdata_d = 32'h0;
    if (rd_hit[`EIPP_SEL_EXT_CTRL]) begin
      rdata_d[7:0] = ext_ctrl_d;
    end
    if (rd_hit[`EIPP_SEL_PERI_PRIO]) begin
      rdata_d[7:0] = peri_prio_d;
    end
    if (rd_hit[`EIPP_SEL_RESET_CTRL]) begin
      rdata_d[7:0] = reset_ctrl_d;
    end
    if (rd_hit[`EIPP_SEL_PERI_ENABLE]) begin
      rdata_d[7:0] = peri_en_d;
    end
    if (rd_hit[`EIPP_SEL_PERI_FLAG]) begin
      rdata_d[7:0] = peri_flag_d;
    end
    if (rd_hit[`EIPP_SEL_IRQ_STATUS]) begin
      rdata_d[3:0] = stat_d;
    end
    if (rd_hit[`EIPP_SEL_IRQ_MASK]) begin
      rdata_d[3:0] = mask_d;
    end
  end

  // Bus answer registers; ready resets high, response always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      rdata_q <= 32'h0;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      req_q <= req_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q <= resp_d;
    end
  end

  // Configuration and flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ctrl_q <= `EIPP_EXT_CTRL_RESET;
      peri_prio_q <= `EIPP_PERI_PRIO_RESET;
      reset_ctrl_q <= `EIPP_ZERO8;
      peri_en_q <= `EIPP_ZERO8;
      peri_flag_q <= `EIPP_ZERO8;
    end else begin
      ext_ctrl_q <= ext_ctrl_d;
      peri_prio_q <= peri_prio_d;
      reset_ctrl_q <= reset_ctrl_d;
      peri_en_q <= peri_en_d;
      peri_flag_q <= peri_flag_d;
    end
  end

  // Status, mask and summary interrupt registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // Core request registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  // Outputs straight from flip-flops
  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;
  assign core_irq_high = hi_q;
  assign core_irq_low = lo_q;
  assign irq = irq_q;

endmodule : eipp_top

/* File: testbench/eipp_partner.sv */
`timescale 1ns/1ps
// Pin pulses and peripheral request strobes
module eipp_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [8:0] fire,
  output logic ext_irq_input_a,
  output logic ext_irq_input_b,
  output logic [6:0] peri_irq_request
);
  logic [5:0] pin_q;
  // Pins stay high three cycles, above the two-cycle minimum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 6'h00;
      peri_irq_request <= 7'h00;
    end else begin
      pin_q <= {pin_q[4:3], fire[8], pin_q[1:0], fire[7]};
      peri_irq_request <= fire[6:0];
    end
  end
  assign ext_irq_input_a = |pin_q[2:0];
  assign ext_irq_input_b = |pin_q[5:3];
endmodule : eipp_partner

/* File: testbench/eipp_top_sva.sv */
`timescale 1ns/1ps
module eipp_top_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic core_irq_high,
  input wire logic core_irq_low
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfers taken at this edge
  wire rd = hsel && hready && htrans == 2'h2 && !hwrite;
  wire wr = hsel && hready && htrans == 2'h2 && hwrite;
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_ctrl_resvd: assert property (rd && haddr[7:0] == 8'h00 |=> !hrdata[5] && !hrdata[2])
    else $error("control reserved bit set");
  a_prio_resvd: assert property (rd && haddr[7:0] == 8'h04 |=> !hrdata[7])
    else $error("priority reserved bit set");
  a_upper_zero: assert property (rd |=> hrdata[31:8] == 24'h000000)
    else $error("read upper bits nonzero");
  a_unmap_zero: assert property (rd && haddr[7:0] > 8'h18 |=> hrdata == 32'h00000000)
    else $error("unmapped read nonzero");
  a_idle_zero: assert property (!rd |=> hrdata == 32'h00000000)
    else $error("hrdata outside data phase");
  a_high_hold: assert property ($fell(core_irq_high) |-> $past(wr, 2) || $past(wr, 3))
    else $error("high request dropped without write");
  a_low_hold: assert property ($fell(core_irq_low) |-> $past(wr, 2) || $past(wr, 3))
    else $error("low request dropped without write");
  c_read: cover property (rd ##1 hrdata != 32'h00000000);
  c_high: cover property ($rose(core_irq_high));
  c_low: cover property ($rose(core_irq_low));
endmodule : eipp_top_sva

bind eipp_top eipp_top_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .core_irq_high, .core_irq_low);

/* File: testbench/eipp_top_tb.sv */
`timescale 1ns/1ps
module eipp_top_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hr_s, rd;
  logic hreadyout, hresp, irq, core_irq_high, core_irq_low, ext_irq_input_a, ext_irq_input_b;
  logic [8:0] fire = 9'h000;
  logic [6:0] peri_irq_request;
  logic [7:0] d;
  int err_total = 0, comparisons = 0, seed = 47, i, k;
  always #20 hclk = ~hclk;
  always @(posedge hclk) hr_s <= hrdata;
  eipp_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_input_a, .ext_irq_input_b,
    .peri_irq_request, .core_irq_high, .core_irq_low, .irq);
  eipp_partner u_far (.hclk, .hresetn, .fire, .ext_irq_input_a, .ext_irq_input_b, .peri_irq_request);
  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Wait for hready with a bound
  task automatic wt;
    int c;
    for (c = 0; c < 50; c++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (c >= 50) begin
      err_total++;
      finish_test();
    end
  endtask : wt
  // One single-word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wt();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, v};
    wt();
    #1 rd = hr_s;
  endtask : xfer
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rd);
  endtask : rc
  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask : settle
  task automatic ev(input int n);
    @(posedge hclk) fire <= 9'h001 << n;
    @(posedge hclk) fire <= 9'h000;
    repeat (8) @(posedge hclk);
  endtask : ev
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rc("ctrl", 8'h00, 8'hc0);
    rc("prio", 8'h04, 8'h7f);
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, 8'h00, 8'hc0);
      ev(7 + i);
      rc("flag", 8'h00, 8'hc0 | (8'h01 << i));
      chk("hi_off", 32'h0, core_irq_high);
      xfer(1'b1, 8'h00, 8'hc0 | (8'h09 << i));
      settle();
      chk("hi_on", 32'h1, core_irq_high);
      xfer(1'b1, 8'h08, 8'h80);
      xfer(1'b1, 8'h00, 8'h09 << i);
      settle();
      chk("lo_on", 32'h1, core_irq_low);
      xfer(1'b1, 8'h00, 8'h08 << i);
      settle();
      chk("lo_clr", 32'h0, core_irq_low);
      xfer(1'b1, 8'h08, 8'h00);
    end
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      xfer(1'b1, 8'h04, d);
      rc("prio_rw", 8'h04, d & 8'h7f);
      xfer(1'b1, 8'h00, d);
      rc("ctrl_rw", 8'h00, d & 8'hdb);
    end
    xfer(1'b1, 8'h00, 8'hc0);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h10, 8'h00);
    xfer(1'b1, 8'h0c, 8'h7f);
    for (i = 0; i < 3; i++) begin
      k = {$random(seed)} % 7;
      ev(k);
      settle();
      chk("peri_hi", 32'h1, core_irq_high);
      xfer(1'b1, 8'h08, 8'h80);
      settle();
      chk("peri_lo", 32'h1, core_irq_low);
      xfer(1'b1, 8'h10, 8'h00);
      xfer(1'b1, 8'h08, 8'h00);
      settle();
      chk("peri_clr", 32'h0, core_irq_low);
    end
    settle();
    chk("irq_masked", 32'h0, irq);
    xfer(1'b1, 8'h18, 8'h0f);
    settle();
    chk("irq_on", 32'h1, irq);
    xfer(1'b1, 8'h14, 8'h0f);
    settle();
    chk("irq_clr", 32'h0, irq);
    @(posedge hclk) hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    rc("ctrl_rst", 8'h00, 8'hc0);
    rc("en_rst", 8'h0c, 8'h00);
    rc("mask_rst", 8'h18, 8'h00);
    rc("status", 8'h14, 8'h00);
    rc("unmapped", 8'h1c, 8'h00);
    finish_test();
  end
endmodule : eipp_top_tb
